// ===== test/fmd_host_model.sv
// fmd_host_model: host cpu side of the parallel byte read handshake
// assumes one byte read per go pulse; pins change just after rising clk
`timescale 1ns/1ps
module fmd_host_model
#(
   parameter int WAIT_MAX = 400
)
(
   input  wire logic       clk,
   input  wire logic       go,
   input  wire logic       slow,
   input  wire logic       output_ready_pulse,
   input  wire logic       output_ready_level,
   input  wire logic [7:0] parallel_data_bus_out,
   output logic            read_strobe,
   output logic      [7:0] rd_byte,
   output logic            rd_done
);
   int n;

   function automatic logic pick(input int k);
      return (k == 0) ? output_ready_pulse : output_ready_level;
   endfunction : pick

   // bounded, so a silent device cannot hang the host
   task automatic wait_on(input int k, input logic v);
      n = 0;
      while (pick(k) !== v && n < WAIT_MAX)
      begin
         @(posedge clk);
         n++;
      end
   endtask : wait_on

   initial
   begin
      read_strobe = 1'b1;
      rd_byte     = 8'h00;
      rd_done     = 1'b0;
      forever
      begin
         @(posedge clk);
         rd_done <= 1'b0;
         if (go)
         begin
            read_strobe <= 1'b0;
            wait_on(0, 1'b0);
            wait_on(0, 1'b1);
            rd_byte     <= parallel_data_bus_out;
            read_strobe <= 1'b1;
            wait_on(1, 1'b1);
            // slow host, still far inside the read window
            if (slow)
               repeat (40) @(posedge clk);
            rd_done <= 1'b1;
         end
      end
   end
endmodule : fmd_host_model

// ===== test/fmd_host_out_tb.sv
// fmd_host_out_tb: self-checking bench for the host output control
// assumes fmd_host_model plays the host cpu on the read pins
`timescale 1ns/1ps
module fmd_host_out_tb;
   import fmd_pkg::*;
   localparam int DO  = 50;
   localparam int RDY = 20;
   logic       clk, rst, serial_select_pin, read_strobe, parallel_store_strobe, go, slow;
   logic [2:0] store_address_inputs, store_addr;
   logic [7:0] parallel_data_bus_in, parallel_data_bus_out, store_data, corr_byte;
   logic [7:0] corr_blk_num, rd_byte;
   logic       parallel_data_bus_oe_n, output_ready_pulse, output_ready_level;
   logic       serial_ready_out, serial_ready_oe_n, transfer_request_n, serial_accept_en;
   logic       store_valid, corr_valid, corr_last, corr_is_vert, corr_is_parity;
   logic       block_clean, rd_done, oscillator_output;
   logic       filt_clk_src, rec_clk_src, bsync_src, fsync_src, bstart_src, fstart_src;
   logic       filter_clock_out, recovered_clock_out, block_sync_indicator;
   logic       frame_sync_indicator, block_start_pulse, frame_start_pulse;
   logic [5:0] srcs;
   int         err_total, tests_run;
   wire  [7:0] low_pins = {filter_clock_out, recovered_clock_out, block_sync_indicator,
                           frame_sync_indicator, block_start_pulse, frame_start_pulse,
                           parallel_data_bus_oe_n, serial_ready_oe_n};
   wire  [7:0] high_pins = {4'h0, output_ready_pulse, output_ready_level,
                            transfer_request_n, oscillator_output};
   assign {filt_clk_src, rec_clk_src, bsync_src, fsync_src, bstart_src, fstart_src} = srcs;

   fmd_host_out #(.DO_CYC(DO), .RDY_CYC(RDY)) uut
   (
      .clk, .rst, .serial_select_pin, .read_strobe, .parallel_store_strobe,
      .store_address_inputs, .parallel_data_bus_in, .parallel_data_bus_out,
      .parallel_data_bus_oe_n, .output_ready_pulse, .output_ready_level, .serial_ready_out,
      .serial_ready_oe_n, .transfer_request_n, .serial_accept_en, .store_valid,
      .store_addr, .store_data, .corr_valid, .corr_byte, .corr_last, .corr_is_vert,
      .corr_is_parity, .corr_blk_num, .block_clean, .filt_clk_src, .rec_clk_src,
      .bsync_src, .fsync_src, .bstart_src, .fstart_src, .filter_clock_out,
      .recovered_clock_out, .block_sync_indicator, .frame_sync_indicator,
      .block_start_pulse, .frame_start_pulse, .oscillator_output
   );

   fmd_host_model host
   (
      .clk, .go, .slow, .output_ready_pulse, .output_ready_level, .parallel_data_bus_out,
      .read_strobe, .rd_byte, .rd_done
   );

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic chk_v(input string nm, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk_v

   task automatic chk_b(input string nm, input logic exp, input logic got);
      chk_v(nm, {7'h0, exp}, {7'h0, got});
   endtask : chk_b

   task automatic chk_n(input string nm, input int exp, input int got);
      tests_run++;
      if (got != exp)
      begin
         err_total++;
         $display("[ERR] %s expected %0d seen %0d", nm, exp, got);
      end
   endtask : chk_n

   task automatic wt(ref logic s, input logic v, input int lim, output int n);
      n = 0;
      while (s !== v && n < lim)
      begin
         @(negedge clk);
         n++;
      end
   endtask : wt

   task automatic send_blk(input logic vert, input logic par, input logic [7:0] num,
                           input logic [7:0] base);
      for (int i = 0; i < 34; i++)
      begin
         @(posedge clk);
         corr_valid     <= 1'b1;
         corr_byte      <= base + 8'(i);
         corr_last      <= (i == 33);
         corr_is_vert   <= vert;
         corr_is_parity <= par;
         corr_blk_num   <= num;
      end
      @(posedge clk);
      corr_valid <= 1'b0;
      corr_last  <= 1'b0;
   endtask : send_blk

   task automatic rd(input logic s, output logic [7:0] b);
      int n;
      @(posedge clk);
      go   <= 1'b1;
      slow <= s;
      @(posedge clk);
      go <= 1'b0;
      wt(rd_done, 1'b1, 2000, n);
      b = rd_byte;
   endtask : rd

   task automatic t_reset();
      repeat (19) @(posedge clk);
      @(negedge clk);
      chk_v("low pins", 8'h00, low_pins);
      chk_v("bus", 8'h00, parallel_data_bus_out);
      chk_v("high pins", 8'h0f, high_pins);
      @(posedge clk);
      rst  <= 1'b0;
      srcs <= 6'h00;
      @(negedge clk);
      chk_b("accept", 1'b0, serial_accept_en);
      @(negedge clk);
      chk_b("accept", 1'b1, serial_accept_en);
   endtask : t_reset

   task automatic t_serial();
      int n;
      logic [7:0] b;
      chk_v("serial bus", 8'h00, parallel_data_bus_out);
      chk_b("serial bus oe_n", 1'b0, parallel_data_bus_oe_n);
      fork
         rd(1'b0, b);
         repeat (RDY + 10)
         begin
            @(negedge clk);
            chk_v("serial ready pins", 8'h03, high_pins >> 2);
         end
      join
      send_blk(1'b1, 1'b0, 8'h05, 8'h10);
      repeat (4) @(negedge clk);
      chk_b("vert ignored", 1'b1, transfer_request_n);
      send_blk(1'b0, 1'b0, 8'h06, 8'h20);
      wt(transfer_request_n, 1'b0, 4, n);
      chk_b("request", 1'b0, transfer_request_n);
      chk_b("serial ready", 1'b0, serial_ready_oe_n);
      chk_b("serial ready pin", 1'b0, serial_ready_out);
      wt(serial_ready_oe_n, 1'b1, DO + 10, n);
      chk_n("serial ready low", DO, n);
      chk_b("request stands", 1'b0, transfer_request_n);
   endtask : t_serial

   task automatic t_parallel();
      int n;
      logic [7:0] b;
      @(posedge clk);
      serial_select_pin <= 1'b0;
      repeat (4) @(negedge clk);
      chk_b("serial out off", 1'b1, serial_ready_oe_n);
      send_blk(1'b0, 1'b0, 8'h07, 8'h40);
      send_blk(1'b0, 1'b1, 8'h09, 8'h80);
      wt(transfer_request_n, 1'b0, 4, n);
      chk_b("par request", 1'b0, transfer_request_n);
      for (int i = 0; i < OUT_BYTES; i++)
      begin
         rd(i == 5, b);
         chk_v("read byte", (i == 0) ? 8'h02 : (i == 1) ? 8'h09 : 8'h7e + 8'(i), b);
      end
      chk_b("serial out still off", 1'b1, serial_ready_oe_n);
   endtask : t_parallel

   task automatic tick(input logic [5:0] v, input int k);
      repeat (k)
      begin
         @(posedge clk);
         srcs <= v;
         @(posedge clk);
         srcs <= 6'h04;
      end
   endtask : tick

   task automatic rd_hdr(input logic [7:0] e0, input logic [7:0] e1);
      int n;
      logic [7:0] b;
      wt(transfer_request_n, 1'b0, 4, n);
      rd(1'b0, b);
      chk_v("status byte", e0, b);
      rd(1'b0, b);
      chk_v("block number", e1, b);
   endtask : rd_hdr

   // full synced dirty frame, then the vertical slots of the next frame
   task automatic t_vert();
      int n;
      @(posedge clk);
      block_clean <= 1'b0;
      tick(6'h05, 1);
      tick(6'h06, VWIN_FIRST + 2);
      send_blk(1'b0, 1'b0, 8'h1e, 8'h00);
      rd_hdr(8'h01, 8'h02);
      tick(6'h06, FRAME_BLOCKS - VWIN_FIRST - 2);
      tick(6'h05, 1);
      tick(6'h06, VWIN_FIRST);
      fork
         send_blk(1'b1, 1'b1, 8'h50, 8'h00);
         wt(transfer_request_n, 1'b1, 40, n);
      join
      chk_n("vert parity refused", 40, n);
      send_blk(1'b1, 1'b0, 8'h33, 8'h00);
      rd_hdr(8'h01, 8'h00);
      send_blk(1'b0, 1'b0, 8'h44, 8'h00);
      rd_hdr(8'h00, 8'h44);
   endtask : t_vert

   task automatic t_store();
      int n;
      @(posedge clk);
      store_address_inputs  <= 3'h4;
      parallel_data_bus_in  <= 8'h5a;
      parallel_store_strobe <= 1'b0;
      // store cycle kept above 1 us
      repeat (130) @(posedge clk);
      chk_b("store bus released", 1'b1, parallel_data_bus_oe_n);
      parallel_store_strobe <= 1'b1;
      wt(store_valid, 1'b1, 8, n);
      chk_b("store pulse", 1'b1, store_valid);
      chk_v("store data", 8'h5a, store_data);
      chk_v("store addr", 8'h04, {5'h0, store_addr});
      @(posedge clk);
      store_address_inputs <= 3'h7;
      parallel_data_bus_in <= 8'ha5;
   endtask : t_store

   task automatic t_mid_reset();
      @(posedge clk);
      rst <= 1'b1;
      repeat (RST_MIN_CYC + 2) @(posedge clk);
      chk_v("reset bus", 8'h00, parallel_data_bus_out);
      chk_b("reset bus oe_n", 1'b0, parallel_data_bus_oe_n);
      chk_b("reset request", 1'b1, transfer_request_n);
      rst <= 1'b0;
      repeat (2) @(negedge clk);
      chk_b("accept again", 1'b1, serial_accept_en);
   endtask : t_mid_reset

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run

   initial
   begin
      err_total             = 0;
      tests_run             = 0;
      rst                   = 1'b1;
      serial_select_pin     = 1'b1;
      parallel_store_strobe = 1'b1;
      store_address_inputs  = 3'h7;
      parallel_data_bus_in  = 8'h00;
      go                    = 1'b0;
      slow                  = 1'b0;
      corr_valid            = 1'b0;
      corr_byte             = 8'h00;
      corr_last             = 1'b0;
      corr_is_vert          = 1'b0;
      corr_is_parity        = 1'b0;
      corr_blk_num          = 8'h00;
      block_clean           = 1'b1;
      srcs                  = 6'h3f;
      t_reset();
      t_serial();
      t_parallel();
      t_vert();
      t_store();
      t_mid_reset();
      complete_run();
   end

   // expected run is a few thousand cycles
   initial
   begin
      repeat (40000) @(posedge clk);
      err_total++;
      complete_run();
   end
endmodule : fmd_host_out_tb

// ===== verilog/fmd_host_out.sv
// fmd_host_out: host-facing output buffer, ready signalling and pin states
// assumes correction engine streams bytes on clk; host pins are asynchronous
`timescale 1ns/1ps
module fmd_host_out
   import fmd_pkg::*;
#(
   parameter int OUT_LEN  = fmd_pkg::OUT_BYTES,
   parameter int DO_CYC   = fmd_pkg::DO_LOW_CYC,
   parameter int RDY_CYC  = fmd_pkg::RDY_LOW_CYC
)
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       serial_select_pin,
   input  wire logic       read_strobe,
   input  wire logic       parallel_store_strobe,
   input  wire logic [2:0] store_address_inputs,
   input  wire logic [7:0] parallel_data_bus_in,
   output logic      [7:0] parallel_data_bus_out,
   output logic            parallel_data_bus_oe_n,
   output logic            output_ready_pulse,
   output logic            output_ready_level,
   output logic            serial_ready_out,
   output logic            serial_ready_oe_n,
   output logic            transfer_request_n,
   output logic            serial_accept_en,
   output logic            store_valid,
   output logic      [2:0] store_addr,
   output logic      [7:0] store_data,
   input  wire logic       corr_valid,
   input  wire logic [7:0] corr_byte,
   input  wire logic       corr_last,
   input  wire logic       corr_is_vert,
   input  wire logic       corr_is_parity,
   input  wire logic [7:0] corr_blk_num,
   input  wire logic       block_clean,
   input  wire logic       filt_clk_src,
   input  wire logic       rec_clk_src,
   input  wire logic       bsync_src,
   input  wire logic       fsync_src,
   input  wire logic       bstart_src,
   input  wire logic       fstart_src,
   output logic            filter_clock_out,
   output logic            recovered_clock_out,
   output logic            block_sync_indicator,
   output logic            frame_sync_indicator,
   output logic            block_start_pulse,
   output logic            frame_start_pulse,
   output logic            oscillator_output
);
   import fmd_pkg::*;

   localparam int DOW = $clog2(DO_CYC + 1);
   localparam int RCW = $clog2(RDY_CYC + 1);

   if (OUT_LEN <= STATUS_BYTES || OUT_LEN > 64)
      $error("OUT_LEN out of range");
   if (DO_CYC < 1 || RDY_CYC < 1)
      $error("timing counts must be at least one");

   // pin synchronisers: pulled-up pins reset high
   logic [2:0]  pin_m;
   logic [2:0]  pin_s;
   logic [10:0] dat_m;
   logic [10:0] dat_s;
   always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
         pin_m <= PIN_RESET;
         pin_s <= PIN_RESET;
         dat_m <= 11'h700;
         dat_s <= 11'h700;
      end
      else
      begin
         pin_m <= {serial_select_pin, read_strobe, parallel_store_strobe};
         pin_s <= pin_m;
         dat_m <= {store_address_inputs, parallel_data_bus_in};
         dat_s <= dat_m;
      end

   wire serial  = pin_s[2];
   wire re_s    = pin_s[1];
   wire pst_s   = pin_s[0];
   logic re_q;
   logic pst_q;
   wire re_fall  = re_q && !re_s;
   wire re_rise  = !re_q && re_s;
   wire pst_rise = !pst_q && pst_s;

   // accept gate opens one clock after release
   always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
         serial_accept_en <= 1'b0;
         re_q             <= 1'b1;
         pst_q            <= 1'b1;
      end
      else
      begin
         serial_accept_en <= 1'b1;
         re_q             <= re_s;
         pst_q            <= pst_s;
      end

   // parallel store of control data on strobe rising edge
   always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
         store_valid <= 1'b0;
         store_addr  <= 3'h0;
         store_data  <= 8'h0;
      end
      else
      begin
         store_valid <= pst_rise && !serial && serial_accept_en;
         if (pst_rise)
         begin
            store_addr <= dat_s[10:8];
            store_data <= dat_s[7:0];
         end
      end

   // demodulator status outputs low in reset, oscillator output high
   logic [5:0] stat_q;
   always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
         stat_q            <= 6'h0;
         oscillator_output <= 1'b1;
      end
      else
      begin
         stat_q <= {filt_clk_src, rec_clk_src, bsync_src, fsync_src, bstart_src, fstart_src};
         oscillator_output <= !oscillator_output;
      end
   assign {filter_clock_out, recovered_clock_out, block_sync_indicator,
           frame_sync_indicator, block_start_pulse, frame_start_pulse} = stat_q;

   // slot scheduling
   logic       vert_slot;
   logic [7:0] vert_num;
   logic       vert_run;
   fmd_slot_sched u_sched (
      .clk         (clk),
      .rst         (rst),
      .block_tick  (bstart_src),
      .frame_tick  (fstart_src),
      .frame_sync  (fsync_src),
      .block_clean (block_clean),
      .vert_slot   (vert_slot),
      .vert_num    (vert_num),
      .vert_run    (vert_run),
      .mem_full    ()
   );

   // output buffer; memory is not cleared by reset
   logic [7:0] obuf [0:OUT_LEN-1];
   logic [5:0] wr_idx;
   logic       blk_ready;
   wire  vert_ok   = !corr_is_parity && vert_run;
   wire  wr_take   = corr_valid && (!corr_is_vert || vert_ok);
   wire  relabel   = !corr_is_vert && vert_slot && !vert_run && !corr_is_parity;
   wire  as_vert   = corr_is_vert || relabel;
   wire  [7:0] st0 = 8'((as_vert ? 1 : 0) << ST_VERT_BIT)
                   | 8'((corr_is_parity ? 1 : 0) << ST_PARITY_BIT);
   wire  [7:0] st1 = as_vert ? vert_num : corr_blk_num;
   wire  [5:0] wr_addr = wr_idx + 6'(STATUS_BYTES);
   wire  wr_end    = wr_take && (corr_last || wr_addr == 6'(OUT_LEN - 1));

   always_ff @(posedge clk)
   begin
      if (wr_take)
         obuf[wr_addr] <= corr_byte;
      if (wr_end)
      begin
         obuf[0] <= st0;
         obuf[1] <= st1;
      end
   end

   always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
         wr_idx    <= 6'h0;
         blk_ready <= 1'b0;
      end
      else
      begin
         blk_ready <= wr_end;
         if (wr_end)
            wr_idx <= 6'h0;
         else if (wr_take)
            wr_idx <= wr_idx + 6'h1;
      end

   // transfer request: falls on ready, rises as the next write starts
   wire wr_start = wr_take && wr_idx == 6'h0;
   always_ff @(posedge clk or posedge rst)
      if (rst)
         transfer_request_n <= 1'b1;
      else if (blk_ready)
         transfer_request_n <= 1'b0;
      else if (wr_start)
         transfer_request_n <= 1'b1;

   // serial ready: low for a fixed time so polling hosts see it
   logic [DOW-1:0] do_cnt;
   always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
         do_cnt            <= '0;
         serial_ready_oe_n <= 1'b0;
      end
      else if (!serial)
      begin
         do_cnt            <= '0;
         serial_ready_oe_n <= 1'b1;
      end
      else if (blk_ready)
      begin
         do_cnt            <= DOW'(DO_CYC - 1);
         serial_ready_oe_n <= 1'b0;
      end
      else if (do_cnt != '0)
         do_cnt <= do_cnt - 1'b1;
      else
         serial_ready_oe_n <= 1'b1;
   assign serial_ready_out = 1'b0;

   // parallel byte read handshake
   fmd_rd_t        rd_st;
   fmd_rd_t        next_rd_st;
   logic [RCW-1:0] rdy_cnt;
   logic [5:0]     rd_idx;
   logic           rdy_q;
   logic           lvl_q;
   wire  rd_go   = re_fall && !serial && serial_accept_en;
   wire  rd_done = rd_st == RD_WAIT && rdy_cnt == '0;

   always_comb
   begin
      next_rd_st = rd_st;
      case (rd_st)
         RD_IDLE: if (rd_go) next_rd_st = RD_WAIT;
         RD_WAIT: if (rd_done) next_rd_st = RD_HOLD;
         RD_HOLD: if (re_rise) next_rd_st = RD_IDLE;
         default: next_rd_st = RD_IDLE;
      endcase
      if (serial)
         next_rd_st = RD_IDLE;
   end

   always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
         rd_st   <= RD_IDLE;
         rdy_cnt <= '0;
         rd_idx  <= 6'h0;
         rdy_q   <= 1'b1;
         lvl_q   <= 1'b1;
      end
      else
      begin
         rd_st <= next_rd_st;
         if (serial || blk_ready)
            rd_idx <= 6'h0;
         else if (rd_st == RD_HOLD && re_rise)
            rd_idx <= (rd_idx == 6'(OUT_LEN - 1)) ? 6'h0 : rd_idx + 6'h1;
         if (rd_go && rd_st == RD_IDLE)
            rdy_cnt <= RCW'(RDY_CYC - 1);
         else if (rdy_cnt != '0)
            rdy_cnt <= rdy_cnt - 1'b1;
         rdy_q <= serial || next_rd_st != RD_WAIT;
         lvl_q <= serial || next_rd_st != RD_HOLD;
      end
   assign output_ready_pulse = rdy_q;
   assign output_ready_level = lvl_q;

   // data bus: low in reset, low in serial, input while store strobe low
   logic [7:0] bus_q;
   logic       bus_oe_n;
   always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
         bus_q    <= 8'h0;
         bus_oe_n <= 1'b0;
      end
      else
      begin
         bus_oe_n <= !serial && !pst_s;
         if (serial)
            bus_q <= 8'h0;
         else if (rd_done)
            bus_q <= obuf[rd_idx];
      end
   assign parallel_data_bus_out  = bus_q;
   assign parallel_data_bus_oe_n = bus_oe_n;

   sequence rd_start_s;
      $fell(re_s) && !serial && rd_st == RD_IDLE;
   endsequence
   sequence rdy_low_s;
      ##1 !output_ready_pulse && output_ready_level;
   endsequence

   serial_bus_low_a : assert property (@(posedge clk) disable iff (rst)
      serial && $past(serial) |-> parallel_data_bus_out == 8'h0 && !parallel_data_bus_oe_n)
      else $error("serial mode bus not driven low");
   serial_ready_high_a : assert property (@(posedge clk) disable iff (rst)
      serial && $past(serial) |-> output_ready_pulse && output_ready_level)
      else $error("serial mode ready outputs not high");
   par_do_release_a : assert property (@(posedge clk) disable iff (rst)
      !serial && !$past(serial) |-> serial_ready_oe_n)
      else $error("serial ready driven in parallel mode");
   ready_int_low_a : assert property (@(posedge clk) disable iff (rst)
      blk_ready |=> !transfer_request_n)
      else $error("transfer request missing on ready");
   ready_do_low_a : assert property (@(posedge clk) disable iff (rst)
      blk_ready && serial |=> !serial_ready_oe_n [*2])
      else $error("serial ready not pulled low on ready");
   accept_open_a : assert property (@(posedge clk) disable iff (rst)
      !$past(rst) |-> serial_accept_en)
      else $error("input control not open after reset");
   rd_cycle_a : assert property (@(posedge clk) disable iff (rst)
      rd_start_s ##0 rdy_low_s |-> ##[1:300] $rose(output_ready_pulse) && !output_ready_level)
      else $error("ready pulse did not return with level low");
   lvl_release_a : assert property (@(posedge clk) disable iff (rst)
      rd_st == RD_HOLD && re_rise && !serial |=> output_ready_level)
      else $error("ready level not released after strobe high");
   ready_after_write_a : assert property (@(posedge clk) disable iff (rst)
      wr_end |=> blk_ready ##1 !transfer_request_n)
      else $error("block not offered right after write");
   // bus turns round one clock after the synced store strobe
   store_bus_in_a : assert property (@(posedge clk) disable iff (rst)
      !$past(serial) && !$past(pst_s) |-> parallel_data_bus_oe_n)
      else $error("data bus driven during parallel store");
   par_bus_drive_a : assert property (@(posedge clk) disable iff (rst)
      !$past(serial) && $past(pst_s) |-> !parallel_data_bus_oe_n)
      else $error("data bus not driven in parallel mode");
   store_pulse_a : assert property (@(posedge clk) disable iff (rst)
      store_valid |=> !store_valid)
      else $error("store pulse longer than one cycle");
endmodule : fmd_host_out

// ===== verilog/fmd_pkg.sv
// fmd_pkg: shared constants of the decoder host output control
// assumes a single 125 MHz clock and an active-high asynchronous reset
// Functional notes
// - serial mode: eight data bus pins driven as outputs, held low
// - serial mode: pulsed ready and level ready held high
// - parallel mode: serial open-drain ready output stays released
// - transfer request interrupt works in both serial and parallel modes
// - mode select defaults to serial when left undriven
// - during reset: clocks, bus, sync indicators, start pulses, serial output low
// - during reset: both ready outputs, interrupt and oscillator output high
// - parallel mode: bus driven low only during reset, then active bus
// - reset clears all registers but not buffer memory
// - input control accepts host data one clock after reset release
// - each horizontally corrected block is offered for output at once
// - vertical correction only with frame sync and not all blocks clean
// - vertical correction starts only after a full 272-block frame
// - horizontal output has data and parity; vertical output only 190 data blocks
// - without vertical correction the vertical slot carries horizontal data
// - buffer written continuously; unread data may be overwritten
// - block ready: serial ready output low, transfer request low
// - horizontal-only periods alternate with horizontal plus vertical periods
// - parallel byte cycle: strobe low, wait ready high, sample, strobe high
package fmd_pkg;
   localparam int CLK_MHZ        = 125;
   localparam int RST_MIN_NS     = 300;
   localparam int RST_MIN_CYC    = (RST_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int RDY_LOW_NS     = 2200;
   localparam int RDY_LOW_CYC    = RDY_LOW_NS * CLK_MHZ / 1000;
   localparam int DO_LOW_US      = 6000;
   localparam int DO_LOW_CYC     = DO_LOW_US * CLK_MHZ;
   localparam int ACCEPT_DLY_CYC = 1;
   localparam int OUT_BYTES      = 36;
   localparam int STATUS_BYTES   = 2;
   localparam int FRAME_BLOCKS   = 272;
   localparam int DATA_BLOCKS    = 190;
   localparam int VWIN_FIRST     = 28;
   localparam int VWIN_LAST      = 217;
   localparam int ST_VERT_BIT    = 0;
   localparam int ST_PARITY_BIT  = 1;
   localparam logic [2:0] PIN_RESET = 3'h7;
   typedef enum logic [1:0] {
      RD_IDLE = 2'b00,
      RD_WAIT = 2'b01,
      RD_HOLD = 2'b10
   } fmd_rd_t;
endpackage : fmd_pkg

// ===== verilog/fmd_slot_sched.sv
// fmd_slot_sched: frame position, frame accumulation and vertical slot timing
// assumes block and frame ticks are one-cycle pulses on clk
`timescale 1ns/1ps
module fmd_slot_sched
   import fmd_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       block_tick,
   input  wire logic       frame_tick,
   input  wire logic       frame_sync,
   input  wire logic       block_clean,
   output logic            vert_slot,
   output logic [7:0]      vert_num,
   output logic            vert_run,
   output logic            mem_full
);
   import fmd_pkg::*;

   logic [8:0] blk_cnt;
   logic [8:0] acc_cnt;
   logic       dirty;
   wire        in_win   = (blk_cnt >= 9'(VWIN_FIRST)) && (blk_cnt <= 9'(VWIN_LAST));
   wire  [8:0] win_off  = blk_cnt - 9'(VWIN_FIRST);
   wire        next_run = frame_sync && mem_full && dirty;

   assign vert_slot = in_win;
   assign vert_num  = win_off[7:0];
   assign mem_full  = (acc_cnt == 9'(FRAME_BLOCKS));

   always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
         blk_cnt  <= 9'h0;
         acc_cnt  <= 9'h0;
         dirty    <= 1'b0;
         vert_run <= 1'b0;
      end
      else if (frame_tick)
      begin
         blk_cnt  <= 9'h0;
         dirty    <= 1'b0;
         vert_run <= next_run;
      end
      else if (block_tick)
      begin
         blk_cnt <= blk_cnt + 9'h1;
         if (!block_clean)
            dirty <= 1'b1;
         // accumulation restarts at any block tick seen without frame sync
         if (!frame_sync)
            acc_cnt <= 9'h0;
         else if (!mem_full)
            acc_cnt <= acc_cnt + 9'h1;
      end

   vert_data_only_a : assert property (@(posedge clk) disable iff (rst)
      vert_slot |-> vert_num < 8'(DATA_BLOCKS))
      else $error("vertical slot number beyond data blocks");
   vert_needs_frame_a : assert property (@(posedge clk) disable iff (rst)
      $rose(vert_run) |-> $past(next_run))
      else $error("vertical correction without full synced dirty frame");
endmodule : fmd_slot_sched
